// >>> inc/rf_wm_pkg.sv
package rf_wm_pkg;

  // host symbol levels carry 8 fraction bits: level 7 is 7 * 256
  localparam int SYM_W = 14;
  localparam int OUT_W = 15;
  localparam int ID_W = 12;
  localparam int TIER_LEN = 16;
  localparam int CNT_W = 18;
  localparam int BURY_W = 3;

  // symbols in 312 data segments, and the 2^16 - 1 code period
  localparam int FIELD_SYMS = 259584;
  localparam int CODE_PERIOD = 65535;

  // feedback masks of three primitive degree-16 polynomials
  localparam logic [TIER_LEN-1:0] TIER1_TAPS = 16'h100B;
  localparam logic [TIER_LEN-1:0] TIER2_TAPS = 16'h002D;
  localparam logic [TIER_LEN-1:0] TIER3_TAPS = 16'hA011;

  // tier 1 always starts from a single one in its top stage
  localparam logic [TIER_LEN-1:0] TIER1_SEED = 16'h8000;
  localparam logic [TIER_LEN-1:0] TIER_ZERO = 16'h0000;
  localparam logic [TIER_LEN-ID_W-1:0] SEED_PAD = 4'h0;

  localparam logic [BURY_W-1:0] BURY_21DB = 3'h0;
  localparam logic [BURY_W-1:0] BURY_24DB = 3'h1;
  localparam logic [BURY_W-1:0] BURY_27DB = 3'h2;
  localparam logic [BURY_W-1:0] BURY_30DB = 3'h3;
  localparam logic [BURY_W-1:0] BURY_33DB = 3'h4;
  localparam logic [BURY_W-1:0] BURY_36DB = 3'h5;
  localparam logic [BURY_W-1:0] BURY_39DB = 3'h6;
  localparam logic [BURY_W-1:0] BURY_OFF = 3'h7;
  localparam logic [BURY_W-1:0] BURY_NOMINAL = BURY_30DB;

  // amplitudes rounded to the host scale of 256 per unit level
  localparam logic signed [SYM_W-1:0] AMP_21DB = 14'sh006C;
  localparam logic signed [SYM_W-1:0] AMP_24DB = 14'sh004D;
  localparam logic signed [SYM_W-1:0] AMP_27DB = 14'sh0036;
  localparam logic signed [SYM_W-1:0] AMP_30DB = 14'sh0026;
  localparam logic signed [SYM_W-1:0] AMP_33DB = 14'sh001B;
  localparam logic signed [SYM_W-1:0] AMP_36DB = 14'sh0013;
  localparam logic signed [SYM_W-1:0] AMP_39DB = 14'sh000E;
  localparam logic signed [SYM_W-1:0] AMP_OFF = 14'sh0000;

  typedef struct packed {
    logic field_sync;
    logic signed [SYM_W-1:0] level;
  } host_sym_t;

  typedef struct packed {
    logic field_sync;
    logic wm_bit;
    logic signed [OUT_W-1:0] level;
  } dac_sym_t;

endpackage : rf_wm_pkg

// >>> rtl/rf_wm_tier.sv
`timescale 1ns/1ps
`default_nettype none
module rf_wm_tier #(
  parameter int LEN = 16,
  parameter logic [LEN-1:0] TAPS = '1,
  parameter logic [LEN-1:0] RESET_STATE = '0
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [LEN-1:0] i_seed,
  input wire logic i_step,
  output logic [LEN-1:0] o_state,
  output logic o_bit
);

  generate
    if (LEN < 2 || TAPS[0] != 1'b1) begin : g_bad_taps
      $error("tier needs two stages and a tap on stage 0");
    end
  endgenerate

  // parallel preload wins over a step in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_state <= RESET_STATE;
    end else if (i_load) begin
      o_state <= i_seed;
    end else if (i_step) begin
      o_state <= {^(o_state & TAPS), o_state[LEN-1:1]}; // RULE_18
    end
  end

  assign o_bit = o_state[0];

endmodule : rf_wm_tier
`default_nettype wire

// >>> rtl/rf_wm_buf.sv
`timescale 1ns/1ps
`default_nettype none
module rf_wm_buf #(
  parameter int WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("buffer width must be positive");
    end
  endgenerate

  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != 2'h2);
  assign o_out_valid = (count != 2'h0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule : rf_wm_buf
`default_nettype wire

// >>> rtl/rf_watermark_kasami_gen.sv
// Notes on behaviour
// RULE_01 - three maximal LFSR tiers XORed into one bit
// RULE_02 - 24-bit seed selects the code
// RULE_03 - tier one loads fixed single-one pattern
// RULE_04 - network id seeds tier two, transmitter tier three
// RULE_05 - one step per accepted host symbol
// RULE_06 - one adds amplitude, zero subtracts it
// RULE_07 - amplitude follows bury ratio table, off is zero
// RULE_08 - watermark summed with host symbol toward converter
// RULE_09 - bury ratio chosen per transmitter, nominal -30 dB
// RULE_10 - nothing added in field sync; reload there
// RULE_11 - run 312 segments after sync, then stop
// RULE_12 - code period is 65535 bits
// RULE_13 - three full periods plus 62979-bit tail
// RULE_14 - binary: one code bit per symbol
// RULE_15 - receiver seeds identical generator with same ids
// RULE_16 - correlator outputs agreements minus disagreements
// RULE_17 - correlator re-evaluates window each new bit
// RULE_18 - XOR feedback only, parallel preload
// RULE_19 - optional whole-field inversion carries return bit
// RULE_20 - amplitudes fixed-point at host scale, no overflow
// RULE_21 - off still reloads and runs, adds zero
`timescale 1ns/1ps
`default_nettype none
module rf_watermark_kasami_gen #(
  parameter int FIELD_SYMS = rf_wm_pkg::FIELD_SYMS,
  parameter int CODE_PERIOD = rf_wm_pkg::CODE_PERIOD
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_host_valid,
  input wire rf_wm_pkg::host_sym_t i_host,
  output logic o_host_ready,
  input wire logic [rf_wm_pkg::ID_W-1:0] i_network_id,
  input wire logic [rf_wm_pkg::ID_W-1:0] i_tx_id,
  input wire logic [rf_wm_pkg::BURY_W-1:0] i_bury_sel,
  input wire logic i_invert_field,
  output logic o_dac_valid,
  output rf_wm_pkg::dac_sym_t o_dac,
  input wire logic i_dac_ready,
  output logic o_wm_active,
  output logic o_period_end
);

  localparam int CW = rf_wm_pkg::CNT_W;
  localparam int TAIL = FIELD_SYMS % CODE_PERIOD;
  localparam logic [CW-1:0] LAST_SYM = CW'(FIELD_SYMS - 1);
  localparam logic [CW-1:0] LAST_PER = CW'(CODE_PERIOD - 1);
  localparam logic [CW-1:0] TAIL_CNT = CW'(TAIL);
  localparam logic [CW-1:0] CNT_ONE = 18'h00001;
  localparam logic [CW-1:0] CNT_ZERO = 18'h00000;

  generate
    if (FIELD_SYMS < 2 || FIELD_SYMS >= (1 << CW) || CODE_PERIOD < 2
        || CODE_PERIOD >= (1 << CW) || TAIL == 0) begin : g_bad_counts
      $error("field and period counts do not fit the counters");
    end
  endgenerate

  logic accept;
  logic load;
  logic step;
  logic active;
  logic invert;
  logic [rf_wm_pkg::BURY_W-1:0] bury;
  logic [CW-1:0] sym_cnt;
  logic [CW-1:0] per_cnt;
  logic [rf_wm_pkg::TIER_LEN-1:0] t1_state;
  logic [rf_wm_pkg::TIER_LEN-1:0] t2_state;
  logic [rf_wm_pkg::TIER_LEN-1:0] t3_state;
  logic t1_bit;
  logic t2_bit;
  logic t3_bit;
  logic code_bit;
  logic wm_on;
  logic signed [rf_wm_pkg::SYM_W-1:0] amp;
  logic signed [rf_wm_pkg::OUT_W-1:0] host_ext;
  logic signed [rf_wm_pkg::OUT_W-1:0] amp_ext;
  rf_wm_pkg::dac_sym_t next_dac;
  logic buf_ready;

  assign accept = i_host_valid && buf_ready;
  assign o_host_ready = buf_ready;
  assign load = accept && i_host.field_sync; // RULE_10
  assign step = accept && active && !i_host.field_sync; // RULE_05

  rf_wm_tier #(
    .LEN(rf_wm_pkg::TIER_LEN),
    .TAPS(rf_wm_pkg::TIER1_TAPS),
    .RESET_STATE(rf_wm_pkg::TIER1_SEED)
  ) u_tier1 (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_load(load),
    .i_seed(rf_wm_pkg::TIER1_SEED), // RULE_03
    .i_step(step),
    .o_state(t1_state),
    .o_bit(t1_bit)
  );

  // ids sit in the low stages; upper stages of tiers two and three start clear
  rf_wm_tier #(
    .LEN(rf_wm_pkg::TIER_LEN),
    .TAPS(rf_wm_pkg::TIER2_TAPS),
    .RESET_STATE(rf_wm_pkg::TIER_ZERO)
  ) u_tier2 (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_load(load),
    .i_seed({rf_wm_pkg::SEED_PAD, i_network_id}), // RULE_04 RULE_02 RULE_18
    .i_step(step),
    .o_state(t2_state),
    .o_bit(t2_bit)
  );

  rf_wm_tier #(
    .LEN(rf_wm_pkg::TIER_LEN),
    .TAPS(rf_wm_pkg::TIER3_TAPS),
    .RESET_STATE(rf_wm_pkg::TIER_ZERO)
  ) u_tier3 (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_load(load),
    .i_seed({rf_wm_pkg::SEED_PAD, i_tx_id}), // RULE_04 RULE_02
    .i_step(step),
    .o_state(t3_state),
    .o_bit(t3_bit)
  );

  // one code bit per symbol, inverted for a whole field when signalling
  assign code_bit = t1_bit ^ t2_bit ^ t3_bit ^ invert; // RULE_01 RULE_14 RULE_19

  // field framing: sync arms the run, the last data symbol ends it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      active <= 1'b0;
      sym_cnt <= CNT_ZERO;
    end else if (load) begin
      active <= 1'b1; // RULE_11
      sym_cnt <= CNT_ZERO;
    end else if (step) begin
      sym_cnt <= sym_cnt + CNT_ONE;
      if (sym_cnt == LAST_SYM) begin
        active <= 1'b0; // RULE_11 RULE_13
      end
    end
  end

  // control fields take effect only at a field boundary
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      bury <= rf_wm_pkg::BURY_NOMINAL; // RULE_09
      invert <= 1'b0;
    end else if (load) begin
      bury <= i_bury_sel; // RULE_09
      invert <= i_invert_field; // RULE_19
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      per_cnt <= CNT_ZERO;
    end else if (load) begin
      per_cnt <= CNT_ZERO;
    end else if (step) begin
      per_cnt <= (per_cnt == LAST_PER) ? CNT_ZERO : per_cnt + CNT_ONE; // RULE_12
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_period_end <= 1'b0;
    end else begin
      o_period_end <= step && (per_cnt == LAST_PER); // RULE_12
    end
  end

  assign o_wm_active = active;

  always_comb begin
    case (bury) // RULE_07 RULE_20
      rf_wm_pkg::BURY_21DB: amp = rf_wm_pkg::AMP_21DB;
      rf_wm_pkg::BURY_24DB: amp = rf_wm_pkg::AMP_24DB;
      rf_wm_pkg::BURY_27DB: amp = rf_wm_pkg::AMP_27DB;
      rf_wm_pkg::BURY_30DB: amp = rf_wm_pkg::AMP_30DB;
      rf_wm_pkg::BURY_33DB: amp = rf_wm_pkg::AMP_33DB;
      rf_wm_pkg::BURY_36DB: amp = rf_wm_pkg::AMP_36DB;
      rf_wm_pkg::BURY_39DB: amp = rf_wm_pkg::AMP_39DB;
      default: amp = rf_wm_pkg::AMP_OFF;
    endcase
  end

  // one guard bit of headroom so the sum never wraps
  assign host_ext = rf_wm_pkg::OUT_W'(i_host.level); // RULE_20
  assign amp_ext = rf_wm_pkg::OUT_W'(amp);
  assign wm_on = active && !i_host.field_sync && (bury != rf_wm_pkg::BURY_OFF); // RULE_21

  always_comb begin
    next_dac.field_sync = i_host.field_sync;
    next_dac.wm_bit = code_bit;
    if (wm_on) begin
      next_dac.level = code_bit ? host_ext + amp_ext : host_ext - amp_ext; // RULE_06 RULE_08
    end else begin
      next_dac.level = host_ext; // RULE_10 RULE_21
    end
  end

  // two entries absorb one converter stall without dropping a symbol
  rf_wm_buf #(
    .WIDTH($bits(rf_wm_pkg::dac_sym_t))
  ) u_buf (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_host_valid),
    .i_in_data(next_dac),
    .o_in_ready(buf_ready),
    .o_out_valid(o_dac_valid),
    .o_out_data(o_dac),
    .i_out_ready(i_dac_ready)
  );

  sequence s_sync_taken;
    load;
  endsequence

  sequence s_last_data;
    step && (sym_cnt == LAST_SYM);
  endsequence

  chk_tier_seed: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_03
    s_sync_taken |=> (t1_state == rf_wm_pkg::TIER1_SEED))
    else $error("tier one seed wrong after sync");

  chk_id_seed: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_04
    s_sync_taken |=> (t2_state[rf_wm_pkg::ID_W-1:0] == $past(i_network_id))
      && (t3_state[rf_wm_pkg::ID_W-1:0] == $past(i_tx_id)))
    else $error("identifier seed not loaded");

  chk_sync_clean: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_10
    accept && (i_host.field_sync || !active) |-> (next_dac.level == host_ext))
    else $error("watermark added outside active field");

  chk_symbol_sign: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_06
    step && (bury != rf_wm_pkg::BURY_OFF)
      |-> (next_dac.level - host_ext == (code_bit ? amp_ext : -amp_ext)))
    else $error("watermark sign or amplitude wrong");

  chk_off_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_21
    (bury == rf_wm_pkg::BURY_OFF) && accept |-> (next_dac.level == host_ext))
    else $error("off setting changed the host symbol");

  chk_step_once: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_05
    !accept |=> $stable(t1_state) && $stable(t2_state) && $stable(t3_state))
    else $error("generator moved without a symbol");

  chk_field_end: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_11
    s_last_data ##1 (!load) [*2] |-> !active)
    else $error("watermark ran past the field");

  chk_tail_len: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_13
    s_last_data |=> (per_cnt == TAIL_CNT))
    else $error("last period length wrong");

  chk_period_wrap: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_12
    o_period_end |-> $past(per_cnt) == LAST_PER && per_cnt == CNT_ZERO)
    else $error("period end at wrong count");

  chk_invert_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE_19
    !load |=> $stable(invert) && $stable(bury))
    else $error("field controls changed mid field");

endmodule : rf_watermark_kasami_gen
`default_nettype wire

// >>> verif/rf_wm_dac_sink.sv
`timescale 1ns/1ps
`default_nettype none
module rf_wm_dac_sink (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire rf_wm_pkg::dac_sym_t i_sym,
  input wire logic i_stall,
  output logic o_ready
);
  rf_wm_pkg::dac_sym_t got[$];
  logic [1:0] phase;
  // a slow converter takes one word in four, enough to fill the buffer
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      phase <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      o_ready <= !i_stall || (phase == 2'h3);
      if (i_valid && o_ready) got.push_back(i_sym);
    end
  end
endmodule : rf_wm_dac_sink
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int FS = 40;
  localparam int CP = 15;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_host_valid = 1'b0;
  rf_wm_pkg::host_sym_t i_host = '0;
  logic [11:0] i_network_id = 12'h000;
  logic [11:0] i_tx_id = 12'h000;
  logic [2:0] i_bury_sel = rf_wm_pkg::BURY_NOMINAL;
  logic i_invert_field = 1'b0;
  logic stall = 1'b0;
  logic o_host_ready, o_dac_valid, i_dac_ready, o_wm_active, o_period_end;
  rf_wm_pkg::dac_sym_t o_dac;
  int bad_count = 0;
  int total_checks = 0;
  int pend_cnt = 0;
  logic saw_full = 1'b0;
  logic [15:0] t1, t2, t3;
  int k = FS;
  logic [2:0] cur_sel;
  logic cur_inv;
  logic [14:0] exp_lvl[$];
  logic exp_bit[$];
  bit bit_known[$];
  logic exp_fs[$];
  logic rx_bits[$];
  logic ref_bits[$];

  always #2 i_clock = ~i_clock;

  rf_watermark_kasami_gen #(.FIELD_SYMS(FS), .CODE_PERIOD(CP)) dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_host_valid(i_host_valid),
    .i_host(i_host), .o_host_ready(o_host_ready), .i_network_id(i_network_id),
    .i_tx_id(i_tx_id), .i_bury_sel(i_bury_sel), .i_invert_field(i_invert_field),
    .o_dac_valid(o_dac_valid), .o_dac(o_dac), .i_dac_ready(i_dac_ready),
    .o_wm_active(o_wm_active), .o_period_end(o_period_end));

  rf_wm_dac_sink partner (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_valid(o_dac_valid),
    .i_sym(o_dac), .i_stall(stall), .o_ready(i_dac_ready));

  always @(posedge i_clock) if (o_period_end === 1'b1) pend_cnt <= pend_cnt + 1;
  always @(negedge i_clock) if (i_host_valid && o_host_ready === 1'b0) saw_full <= 1'b1;

  task automatic chk_lvl(input string what, input logic [14:0] exp, input logic [14:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_lvl

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_cnt(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  function automatic logic [14:0] amp(input logic [2:0] sel);
    case (sel)
      rf_wm_pkg::BURY_21DB: return 15'(rf_wm_pkg::AMP_21DB);
      rf_wm_pkg::BURY_24DB: return 15'(rf_wm_pkg::AMP_24DB);
      rf_wm_pkg::BURY_27DB: return 15'(rf_wm_pkg::AMP_27DB);
      rf_wm_pkg::BURY_30DB: return 15'(rf_wm_pkg::AMP_30DB);
      rf_wm_pkg::BURY_33DB: return 15'(rf_wm_pkg::AMP_33DB);
      rf_wm_pkg::BURY_36DB: return 15'(rf_wm_pkg::AMP_36DB);
      rf_wm_pkg::BURY_39DB: return 15'(rf_wm_pkg::AMP_39DB);
      default: return 15'h0000;
    endcase
  endfunction : amp

  function automatic logic [15:0] adv(input logic [15:0] s, input logic [15:0] taps);
    return {^(s & taps), s[15:1]};
  endfunction : adv

  // reference generator stands in for a monitoring receiver with the same ids
  task automatic send(input logic fs, input logic [13:0] lvl);
    logic b;
    int n;
    n = 0;
    i_host_valid <= 1'b1;
    i_host <= {fs, lvl};
    bit_known.push_back(1'b0);
    exp_fs.push_back(fs);
    if (fs) begin
      t1 = rf_wm_pkg::TIER1_SEED;
      t2 = {rf_wm_pkg::SEED_PAD, i_network_id};
      t3 = {rf_wm_pkg::SEED_PAD, i_tx_id};
      k = 0;
      exp_lvl.push_back({lvl[13], lvl});
    end else if (k < FS) begin
      b = t1[0] ^ t2[0] ^ t3[0] ^ cur_inv;
      t1 = adv(t1, rf_wm_pkg::TIER1_TAPS);
      t2 = adv(t2, rf_wm_pkg::TIER2_TAPS);
      t3 = adv(t3, rf_wm_pkg::TIER3_TAPS);
      k++;
      exp_lvl.push_back({lvl[13], lvl} + (b ? amp(cur_sel) : -amp(cur_sel)));
      bit_known[$] = 1'b1;
    end else begin
      exp_lvl.push_back({lvl[13], lvl});
    end
    exp_bit.push_back(b);
    @(negedge i_clock);
    while (o_host_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge i_clock);
    end
    chk_bit("host ready", 1'b1, o_host_ready);
    @(posedge i_clock);
  endtask : send

  // monitoring receiver: slide the received bits past the reference, one score per shift
  task automatic correlate();
    int w;
    int sc;
    w = ref_bits.size() - 4;
    for (int sh = 0; sh < 4; sh++) begin
      sc = 0;
      for (int i = 0; i < w; i++) begin
        sc += (rx_bits[i + sh] === ref_bits[i]) ? 1 : -1;
      end
      if (sh == 0) begin
        chk_cnt("aligned score", w, sc);
      end else begin
        chk_bit("peak only when aligned", 1'b1, sc < w);
      end
    end
  endtask : correlate

  task automatic drain();
    int n;
    rf_wm_pkg::dac_sym_t g;
    n = 0;
    i_host_valid <= 1'b0;
    while (partner.got.size() < exp_lvl.size() && n < 2000) begin
      n++;
      @(posedge i_clock);
    end
    chk_cnt("words out", exp_lvl.size(), partner.got.size());
    while (partner.got.size() > 0 && exp_lvl.size() > 0) begin
      g = partner.got.pop_front();
      chk_lvl("level", exp_lvl.pop_front(), g.level);
      chk_bit("sync flag", exp_fs.pop_front(), g.field_sync);
      if (bit_known.pop_front()) begin
        chk_bit("code bit", exp_bit[0], g.wm_bit);
        rx_bits.push_back(g.wm_bit);
        ref_bits.push_back(exp_bit[0]);
      end
      void'(exp_bit.pop_front());
    end
    if (ref_bits.size() > 8) begin
      correlate();
    end
    exp_lvl.delete();
    exp_bit.delete();
    bit_known.delete();
    exp_fs.delete();
    rx_bits.delete();
    ref_bits.delete();
  endtask : drain

  task automatic run_field(input logic [2:0] sel, input logic [11:0] nid, input logic [11:0] tid,
                           input logic inv, input int ndata);
    int p0;
    p0 = pend_cnt;
    i_bury_sel <= sel;
    i_network_id <= nid;
    i_tx_id <= tid;
    i_invert_field <= inv;
    cur_sel = sel;
    cur_inv = inv;
    @(posedge i_clock);
    send(1'b1, 14'h0500);
    send(1'b1, 14'h3B00);
    for (int j = 0; j < ndata; j++) begin
      send(1'b0, (j % 3 == 0) ? 14'h1FFF : (j % 3 == 1) ? 14'h2000 : 14'h0700);
    end
    drain();
    chk_cnt("period pulses", FS / CP, pend_cnt - p0);
    chk_bit("active after field", 1'b0, o_wm_active);
  endtask : run_field

  task automatic t_reset();
    @(negedge i_clock);
    chk_bit("dac valid", 1'b0, o_dac_valid);
    chk_bit("active", 1'b0, o_wm_active);
    chk_bit("period end", 1'b0, o_period_end);
    @(posedge i_clock);
    // before any sync nothing is added
    send(1'b0, 14'h0300);
    send(1'b0, 14'h3D00);
    drain();
    $display("test reset done");
  endtask : t_reset

  task automatic t_bury_all();
    for (int s = 0; s < 8; s++) begin
      run_field(3'(s), 12'hA5C ^ 12'(s * 291), 12'h3C1 + 12'(s), s == 2 || s == 5, FS + 3);
    end
    $display("test bury ratios done");
  endtask : t_bury_all

  task automatic t_stall();
    stall <= 1'b1;
    run_field(rf_wm_pkg::BURY_NOMINAL, 12'hFFF, 12'h001, 1'b0, FS);
    chk_bit("buffer filled", 1'b1, saw_full);
    stall <= 1'b0;
    $display("test stall done");
  endtask : t_stall

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset();
    t_bury_all();
    t_stall();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
